// [ett_timer.sv]
// eight-bit timer/counter with one compare unit and register port
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ett_defs.svh"
module ett_timer
  import ett_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  output logic compare_output_pin,
  output logic overflow_irq,
  output logic compare_irq
);
  logic [7:0] count_value_reg, next_count_value_reg;
  logic [7:0] compare_value_reg, next_compare_value_reg;
  logic [7:0] compare_buffer, next_compare_buffer;
  logic [1:0] timer_flag_reg, next_timer_flag_reg;
  logic [1:0] timer_mask_reg, next_timer_mask_reg;
  logic [6:0] control, next_control;
  logic [9:0] prescale, next_prescale;
  logic [2:0] ext_sync, next_ext_sync;
  logic count_down, next_count_down;
  logic match_pend, next_match_pend;
  logic block_match, next_block_match;
  logic wave, next_wave;
  logic [7:0] next_rdata;
  logic next_ovf_irq, next_cmp_irq;
  ett_clksel_t clock_select_field;
  ett_mode_t waveform_mode_field;
  logic [1:0] com_field;
  logic timer_tick;
  logic is_pwm;
  logic match;
  logic [7:0] top;
  logic cnt_wr;
  logic set_ovf, set_cmp, clr_ovf, clr_cmp;

  assign clock_select_field = ett_clksel_t'(control[`ETT_CTRL_CS_LSB +: 3]);
  assign waveform_mode_field = ett_mode_t'(control[`ETT_CTRL_WGM_LSB +: 2]);
  assign com_field = control[`ETT_CTRL_COM_LSB +: 2];
  assign is_pwm = (waveform_mode_field == ETT_MODE_PHASE_PWM) ||
                  (waveform_mode_field == ETT_MODE_FAST_PWM);
  assign match = (count_value_reg == compare_value_reg);
  assign top = (waveform_mode_field == ETT_MODE_CTC) ? compare_value_reg : `ETT_MAX;
  assign cnt_wr = reg_wr && (reg_addr == `ETT_ADDR_COUNT);

  // tick source and edge selection
  always_comb begin
    next_prescale = prescale + 10'h001;
    next_ext_sync = {ext_sync[1:0], external_count_pin};
    case (clock_select_field)
      ETT_CS_OFF: timer_tick = 1'b0;
      ETT_CS_DIV1: timer_tick = 1'b1;
      ETT_CS_DIV8: timer_tick = (prescale[2:0] == 3'h7);
      ETT_CS_DIV64: timer_tick = (prescale[5:0] == 6'h3F);
      ETT_CS_DIV256: timer_tick = (prescale[7:0] == 8'hFF);
      ETT_CS_DIV1024: timer_tick = (prescale == 10'h3FF);
      ETT_CS_EXT_FALL: timer_tick = ext_sync[2] && !ext_sync[1];
      ETT_CS_EXT_RISE: timer_tick = !ext_sync[2] && ext_sync[1];
      default: timer_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prescale <= 10'h000;
      ext_sync <= 3'h0;
    end else begin
      prescale <= next_prescale;
      ext_sync <= next_ext_sync;
    end
  end

  // counter, compare, flags, waveform and register port
  always_comb begin
    next_count_value_reg = count_value_reg;
    next_count_down = count_down;
    next_compare_value_reg = compare_value_reg;
    next_compare_buffer = compare_buffer;
    next_timer_flag_reg = timer_flag_reg;
    next_timer_mask_reg = timer_mask_reg;
    next_control = control;
    next_match_pend = match_pend;
    next_block_match = block_match;
    next_wave = wave;
    next_rdata = `ETT_RESET_BYTE;
    set_ovf = 1'b0;
    set_cmp = 1'b0;
    clr_ovf = 1'b0;
    clr_cmp = 1'b0;
    if (match && !block_match) begin
      next_match_pend = 1'b1;
    end
    if (timer_tick) begin
      // a match first seen in a tick cycle waits for the following tick
      next_match_pend = match && !block_match && !match_pend;
      next_block_match = 1'b0;
      if (match_pend) begin
        set_cmp = 1'b1;
      end
      case (waveform_mode_field)
        ETT_MODE_PHASE_PWM: begin
          if (count_down) begin
            if (count_value_reg == `ETT_BOTTOM) begin
              next_count_down = 1'b0;
              next_count_value_reg = count_value_reg + 8'h01;
              set_ovf = 1'b1;
            end else begin
              next_count_value_reg = count_value_reg - 8'h01;
            end
          end else if (count_value_reg == `ETT_MAX) begin
            next_count_down = 1'b1;
            next_count_value_reg = count_value_reg - 8'h01;
            next_compare_value_reg = compare_buffer;
          end else begin
            next_count_value_reg = count_value_reg + 8'h01;
          end
        end
        ETT_MODE_CTC: begin
          if (count_value_reg == top) begin
            next_count_value_reg = `ETT_BOTTOM;
          end else begin
            next_count_value_reg = count_value_reg + 8'h01;
          end
          if (count_value_reg == `ETT_MAX) begin
            set_ovf = 1'b1;
          end
        end
        default: begin
          next_count_down = 1'b0;
          next_count_value_reg = count_value_reg + 8'h01;
          if (count_value_reg == top) begin
            set_ovf = 1'b1;
            if (waveform_mode_field == ETT_MODE_FAST_PWM) begin
              next_compare_value_reg = compare_buffer;
            end
          end
        end
      endcase
      if (match_pend) begin
        case (waveform_mode_field)
          ETT_MODE_PHASE_PWM: next_wave = com_field[1] ? !count_down : wave;
          ETT_MODE_FAST_PWM: next_wave = com_field[1] ? 1'b0 : wave;
          default: next_wave = (com_field == 2'b01) ? !wave :
                               (com_field == 2'b10) ? 1'b0 :
                               (com_field == 2'b11) ? 1'b1 : wave;
        endcase
      end else if (waveform_mode_field == ETT_MODE_FAST_PWM && count_value_reg == `ETT_MAX &&
                   com_field[1]) begin
        next_wave = 1'b1;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        `ETT_ADDR_CONTROL: next_control = reg_wdata[6:0];
        `ETT_ADDR_COUNT: begin
          next_count_value_reg = reg_wdata;
          next_block_match = 1'b1;
          next_match_pend = 1'b0;
        end
        `ETT_ADDR_COMPARE: begin
          next_compare_buffer = reg_wdata;
          if (!is_pwm) begin
            next_compare_value_reg = reg_wdata;
          end
        end
        `ETT_ADDR_FLAG: begin
          // write one clears, but a same-cycle set wins
          clr_ovf = reg_wdata[`ETT_FLAG_OVF];
          clr_cmp = reg_wdata[`ETT_FLAG_CMP];
        end
        `ETT_ADDR_MASK: next_timer_mask_reg = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `ETT_ADDR_CONTROL: next_rdata = {1'b0, control};
        `ETT_ADDR_COUNT: next_rdata = count_value_reg;
        `ETT_ADDR_COMPARE: next_rdata = is_pwm ? compare_buffer : compare_value_reg;
        `ETT_ADDR_FLAG: next_rdata = {6'h00, timer_flag_reg};
        `ETT_ADDR_MASK: next_rdata = {6'h00, timer_mask_reg};
        default: next_rdata = `ETT_RESET_BYTE;
      endcase
    end
    next_timer_flag_reg[`ETT_FLAG_OVF] = (timer_flag_reg[`ETT_FLAG_OVF] && !clr_ovf) || set_ovf;
    next_timer_flag_reg[`ETT_FLAG_CMP] = (timer_flag_reg[`ETT_FLAG_CMP] && !clr_cmp) || set_cmp;
    next_ovf_irq = next_timer_flag_reg[`ETT_FLAG_OVF] && next_timer_mask_reg[`ETT_FLAG_OVF];
    next_cmp_irq = next_timer_flag_reg[`ETT_FLAG_CMP] && next_timer_mask_reg[`ETT_FLAG_CMP];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_value_reg <= `ETT_RESET_BYTE;
      compare_value_reg <= `ETT_RESET_BYTE;
      compare_buffer <= `ETT_RESET_BYTE;
      timer_flag_reg <= 2'b00;
      timer_mask_reg <= 2'b00;
      control <= 7'h00;
      count_down <= 1'b0;
      match_pend <= 1'b0;
      block_match <= 1'b0;
      wave <= 1'b0;
      reg_rdata <= `ETT_RESET_BYTE;
      overflow_irq <= 1'b0;
      compare_irq <= 1'b0;
      compare_output_pin <= 1'b0;
    end else begin
      count_value_reg <= next_count_value_reg;
      compare_value_reg <= next_compare_value_reg;
      compare_buffer <= next_compare_buffer;
      timer_flag_reg <= next_timer_flag_reg;
      timer_mask_reg <= next_timer_mask_reg;
      control <= next_control;
      count_down <= next_count_down;
      match_pend <= next_match_pend;
      block_match <= next_block_match;
      wave <= next_wave;
      reg_rdata <= next_rdata;
      overflow_irq <= next_ovf_irq;
      compare_irq <= next_cmp_irq;
      compare_output_pin <= next_wave;
    end
  end

  sequence s_stopped;
    clock_select_field == ETT_CS_OFF && !cnt_wr;
  endsequence

  AST_STOP_HOLD: assert property (@(posedge clk) disable iff (rst)
    s_stopped |=> $stable(count_value_reg))
    else $error("count moved while stopped");
  AST_WRITE_WINS: assert property (@(posedge clk) disable iff (rst)
    cnt_wr |=> count_value_reg == $past(reg_wdata))
    else $error("count write lost");
  AST_CMP_FLAG: assert property (@(posedge clk) disable iff (rst)
    timer_tick && match_pend && !(reg_wr && reg_addr == `ETT_ADDR_FLAG) |=>
    timer_flag_reg[`ETT_FLAG_CMP])
    else $error("compare flag not set");
  AST_MATCH_PEND: assert property (@(posedge clk) disable iff (rst)
    match && !block_match && !timer_tick && !cnt_wr |=> match_pend)
    else $error("match missed");
  AST_DIRECT_CMP: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `ETT_ADDR_COMPARE && !is_pwm |=>
    compare_value_reg == $past(reg_wdata))
    else $error("direct compare write lost");
  AST_BUFFERED_CMP: assert property (@(posedge clk) disable iff (rst)
    is_pwm && !timer_tick |=> $stable(compare_value_reg))
    else $error("compare changed off tick in pwm");
  AST_CTC_CLEAR: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_CTC && count_value_reg == compare_value_reg &&
    !cnt_wr |=> count_value_reg == `ETT_BOTTOM)
    else $error("ctc did not clear");
  AST_OVF_IRQ: assert property (@(posedge clk) disable iff (rst)
    overflow_irq == (timer_flag_reg[`ETT_FLAG_OVF] && timer_mask_reg[`ETT_FLAG_OVF]))
    else $error("overflow irq without flag");
  AST_COUNT_UP: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_NORMAL && !cnt_wr |=>
    count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("normal mode did not count");
  AST_CMP_IRQ: assert property (@(posedge clk) disable iff (rst)
    compare_irq == (timer_flag_reg[`ETT_FLAG_CMP] && timer_mask_reg[`ETT_FLAG_CMP]))
    else $error("compare irq does not follow flag and mask");

  // register port
  AST_RESET_CLEAR: assert property (@(posedge clk)
    rst |=> count_value_reg == `ETT_RESET_BYTE && compare_value_reg == `ETT_RESET_BYTE &&
    timer_flag_reg == 2'b00 && timer_mask_reg == 2'b00 && control == 7'h00)
    else $error("state not cleared by reset");
  AST_COUNT_READ: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `ETT_ADDR_COUNT |=> reg_rdata == $past(count_value_reg))
    else $error("count read wrong");
  AST_FLAG_READ: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `ETT_ADDR_FLAG |=> reg_rdata == {6'h00, $past(timer_flag_reg)})
    else $error("flag read wrong");
  AST_COMPARE_READ: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `ETT_ADDR_COMPARE |=>
    reg_rdata == $past(is_pwm ? compare_buffer : compare_value_reg))
    else $error("compare read wrong");
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> reg_rdata == `ETT_RESET_BYTE)
    else $error("read data without read strobe");

  // counting and flags
  AST_HOLD_NO_TICK: assert property (@(posedge clk) disable iff (rst)
    !timer_tick && !cnt_wr |=> $stable(count_value_reg))
    else $error("count moved without tick");
  AST_WRITE_BLOCK: assert property (@(posedge clk) disable iff (rst)
    cnt_wr |=> !match_pend)
    else $error("count write did not block match");
  AST_MATCH_TICK: assert property (@(posedge clk) disable iff (rst)
    timer_tick && match && !block_match && !match_pend && !cnt_wr |=> match_pend)
    else $error("match in tick cycle missed");
  AST_OVF_TOP: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field != ETT_MODE_PHASE_PWM && count_value_reg == `ETT_MAX |=>
    timer_flag_reg[`ETT_FLAG_OVF])
    else $error("overflow flag not set at max");
  AST_PHASE_TURN: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_PHASE_PWM && !count_down &&
    count_value_reg == `ETT_MAX && !cnt_wr |=> count_down &&
    count_value_reg == (`ETT_MAX - 8'h01) && compare_value_reg == $past(compare_buffer))
    else $error("phase pwm did not turn at max");
  AST_PHASE_BOTTOM: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_PHASE_PWM && count_down &&
    count_value_reg == `ETT_BOTTOM |=> !count_down && timer_flag_reg[`ETT_FLAG_OVF])
    else $error("phase pwm did not turn at bottom");
  AST_FAST_RELOAD: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_FAST_PWM && count_value_reg == `ETT_MAX |=>
    compare_value_reg == $past(compare_buffer))
    else $error("fast pwm compare not reloaded");

  // waveform and count pin
  sequence s_toggle_event;
    timer_tick && waveform_mode_field == ETT_MODE_CTC && com_field == 2'b01 && match_pend;
  endsequence

  sequence s_pin_rise;
    !external_count_pin ##1 external_count_pin;
  endsequence

  sequence s_pin_fall;
    external_count_pin ##1 !external_count_pin;
  endsequence

  AST_CTC_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    s_toggle_event |=> compare_output_pin != $past(compare_output_pin))
    else $error("ctc output did not toggle");
  AST_FAST_SET: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_FAST_PWM && com_field[1] && !match_pend &&
    count_value_reg == `ETT_MAX |=> compare_output_pin)
    else $error("fast pwm output not set at max");
  AST_FAST_CLEAR: assert property (@(posedge clk) disable iff (rst)
    timer_tick && waveform_mode_field == ETT_MODE_FAST_PWM && com_field[1] && match_pend |=>
    !compare_output_pin)
    else $error("fast pwm output not cleared on match");
  AST_EXT_RISE: assert property (@(posedge clk) disable iff (rst)
    s_pin_rise ##2 (clock_select_field == ETT_CS_EXT_RISE) |-> timer_tick)
    else $error("rising count edge missed");
  AST_EXT_FALL: assert property (@(posedge clk) disable iff (rst)
    s_pin_fall ##2 (clock_select_field == ETT_CS_EXT_FALL) |-> timer_tick)
    else $error("falling count edge missed");
endmodule

// [ett_defs.svh]
// register offsets, field positions, reset values and count limits for the eight-bit timer
// Notes on behaviour
// - Count and compare registers are both eight bits and software accessible.
// - Every timer interrupt request shows as a bit in the flag register.
// - Each request is gated by its own mask register bit.
// - Tick comes from the internal prescaler or the external count pin.
// - Clock select picks source and active edge; its output is the tick.
// - With no source selected the counter holds its value.
// - Compare value is compared with the count every cycle, in every mode.
// - A buffer stage holds software compare writes before the comparator.
// - Comparator result drives PWM or frequency output on the compare pin.
// - A compare match sets the compare match flag.
// - Count 0x00 is the bottom of the range.
// - Count 0xFF is the maximum of the counter.
// - Top is 0xFF or the compare value, chosen by mode.
// - A mode clears the counter on compare match.
// - Two interrupt sources: overflow and compare match.
// - A glitch-free phase-correct PWM mode is offered.
// - Exactly one compare unit works against the single counter.
// - On each tick the counter clears, counts up or down; otherwise holds.
// - A software count write beats any clear or count in that cycle.
// - Compare flag sets on the tick after the cycle with count equal compare.
// - Compare buffering only in PWM modes; otherwise writes go direct.
`ifndef ETT_DEFS_SVH
`define ETT_DEFS_SVH
`define ETT_ADDR_CONTROL 8'h00
`define ETT_ADDR_COUNT 8'h01
`define ETT_ADDR_COMPARE 8'h02
`define ETT_ADDR_FLAG 8'h03
`define ETT_ADDR_MASK 8'h04
`define ETT_CTRL_CS_LSB 0
`define ETT_CTRL_WGM_LSB 3
`define ETT_CTRL_COM_LSB 5
`define ETT_FLAG_OVF 0
`define ETT_FLAG_CMP 1
`define ETT_BOTTOM 8'h00
`define ETT_MAX 8'hFF
`define ETT_RESET_BYTE 8'h00
`endif

// [ett_pkg.sv]
// types for the eight-bit timer
package ett_pkg;
  typedef enum logic [1:0] {
    ETT_MODE_NORMAL = 2'b00,
    ETT_MODE_PHASE_PWM = 2'b01,
    ETT_MODE_CTC = 2'b10,
    ETT_MODE_FAST_PWM = 2'b11
  } ett_mode_t;
  typedef enum logic [2:0] {
    ETT_CS_OFF = 3'b000,
    ETT_CS_DIV1 = 3'b001,
    ETT_CS_DIV8 = 3'b010,
    ETT_CS_DIV64 = 3'b011,
    ETT_CS_DIV256 = 3'b100,
    ETT_CS_DIV1024 = 3'b101,
    ETT_CS_EXT_FALL = 3'b110,
    ETT_CS_EXT_RISE = 3'b111
  } ett_clksel_t;
endpackage

// [ett_event_src.sv]
// external event source driving the timer count pin
`timescale 1ns/1ps
module ett_event_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  output logic pin,
  output logic done
);
  logic [7:0] left;
  logic [2:0] ph;
  initial begin
    pin = 1'b0;
    done = 1'b1;
    left = 8'h00;
    ph = 3'h0;
  end
  // four cycles high, four low, held low between bursts
  always @(posedge clk) begin
    if (go && done) begin
      left <= n_pulses;
      done <= 1'b0;
      ph <= 3'h0;
    end else if (!done) begin
      ph <= ph + 3'h1;
      pin <= ~ph[2] & ~(ph == 3'h7);
      if (ph == 3'h7) begin
        left <= left - 8'h01;
        done <= (left == 8'h01);
      end
    end
  end
endmodule

// [ett_timer_test.sv]
// self-checking bench for the eight-bit timer
`timescale 1ns/1ps
`include "ett_defs.svh"
module ett_timer_test
  import ett_pkg::*;
;
  typedef struct {logic [7:0] value; logic [7:0] mask; string name;} ett_exp_t;
  logic clk = 1'b0;
  logic rst, reg_wr, reg_rd, ext_pin, cmp_pin, ovf_irq, cmp_irq, go, src_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, n_pulses;
  logic rd_q = 1'b0;
  logic [15:0] lfsr;
  logic [1:0] pins;
  int n_mismatch = 0;
  int compares = 0;
  int divs[4] = '{8, 64, 256, 1024};
  ett_exp_t expq[$];
  ett_exp_t e;
  always #4 clk = ~clk;
  ett_timer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_count_pin(ext_pin),
    .compare_output_pin(cmp_pin), .overflow_irq(ovf_irq), .compare_irq(cmp_irq));
  ett_event_src src (.clk(clk), .go(go), .n_pulses(n_pulses), .pin(ext_pin), .done(src_done));
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  function automatic logic [7:0] ctl(ett_clksel_t cs, ett_mode_t m, logic [1:0] com);
    return {1'b0, com, m, cs};
  endfunction
  task automatic check(string name, logic [7:0] exp, logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] v, logic [7:0] m, string name);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back('{v, m, name});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic burst;
    int k;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (src_done !== 1'b1 && k < 200);
    repeat (6) @(posedge clk);
  endtask
  task automatic pin_both(string name, int n);
    pins = 2'b00;
    repeat (n) begin
      @(posedge clk);
      if (cmp_pin === 1'b1) pins[1] = 1'b1;
      else if (cmp_pin === 1'b0) pins[0] = 1'b1;
    end
    check(name, 8'h03, {6'h00, pins});
  endtask
  // read data stand in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      e = expq.pop_front();
      check(e.name, e.value & e.mask, reg_rdata & e.mask);
    end
    rd_q <= reg_rd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    n_pulses = 8'h05;
    lfsr = 16'h82DF;  // seed 33503
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(i), 8'h00, 8'hFF, "reset value");
    wr(8'h07, 8'hA5);
    rd(8'h07, 8'h00, 8'hFF, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(`ETT_ADDR_COUNT, lfsr[7:0]);
      wr(`ETT_ADDR_COMPARE, lfsr[15:8]);
      repeat (5) @(posedge clk);
      rd(`ETT_ADDR_COUNT, lfsr[7:0], 8'hFF, "count held");
      rd(`ETT_ADDR_COMPARE, lfsr[15:8], 8'hFF, "compare direct");
    end
    wr(`ETT_ADDR_COUNT, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(`ETT_ADDR_CONTROL, ctl(i == 0 ? ETT_CS_OFF : (i == 1 ? ETT_CS_EXT_RISE :
        ETT_CS_EXT_FALL), ETT_MODE_NORMAL, 2'b00));
      burst();
      wr(`ETT_ADDR_CONTROL, 8'h00);
      rd(`ETT_ADDR_COUNT, 8'(5 * i), 8'hFF, "event count");
    end
    for (int i = 0; i < 4; i++) begin
      wr(`ETT_ADDR_COUNT, 8'h00);
      wr(`ETT_ADDR_CONTROL, ctl(ett_clksel_t'(i + 2), ETT_MODE_NORMAL, 2'b00));
      repeat (4 * divs[i] - 2) @(posedge clk);
      wr(`ETT_ADDR_CONTROL, 8'h00);
      rd(`ETT_ADDR_COUNT, 8'h04, 8'hFF, "prescaled count");
    end
    wr(`ETT_ADDR_COUNT, 8'hFD);
    wr(`ETT_ADDR_CONTROL, ctl(ETT_CS_DIV1, ETT_MODE_NORMAL, 2'b00));
    repeat (6) @(posedge clk);
    wr(`ETT_ADDR_CONTROL, 8'h00);
    rd(`ETT_ADDR_FLAG, 8'h01, 8'h01, "overflow flag");
    check("overflow irq masked", 8'h00, {7'h00, ovf_irq});
    wr(`ETT_ADDR_MASK, 8'h01);
    repeat (3) @(posedge clk);
    check("overflow irq", 8'h01, {7'h00, ovf_irq});
    wr(`ETT_ADDR_FLAG, 8'h03);
    repeat (3) @(posedge clk);
    check("overflow irq cleared", 8'h00, {7'h00, ovf_irq});
    rd(`ETT_ADDR_FLAG, 8'h00, 8'h03, "flags cleared");
    wr(`ETT_ADDR_CONTROL, ctl(ETT_CS_DIV1, ETT_MODE_NORMAL, 2'b00));
    wr(`ETT_ADDR_COUNT, 8'h40);
    wr(`ETT_ADDR_CONTROL, 8'h00);
    rd(`ETT_ADDR_COUNT, 8'h42, 8'hFF, "count write wins");
    wr(`ETT_ADDR_COUNT, 8'h00);
    wr(`ETT_ADDR_COMPARE, 8'h03);
    wr(`ETT_ADDR_FLAG, 8'h03);
    wr(`ETT_ADDR_MASK, 8'h02);
    check("compare irq masked", 8'h00, {7'h00, cmp_irq});
    wr(`ETT_ADDR_CONTROL, ctl(ETT_CS_DIV1, ETT_MODE_CTC, 2'b01));
    for (int i = 0; i < 6; i++) rd(`ETT_ADDR_COUNT, 8'h00, 8'hFC, "ctc count");
    pin_both("ctc toggle", 16);
    check("compare irq", 8'h01, {7'h00, cmp_irq});
    wr(`ETT_ADDR_CONTROL, 8'h00);
    rd(`ETT_ADDR_FLAG, 8'h02, 8'h02, "compare flag");
    wr(`ETT_ADDR_COMPARE, 8'h80);
    wr(`ETT_ADDR_CONTROL, ctl(ETT_CS_DIV1, ETT_MODE_PHASE_PWM, 2'b10));
    rd(`ETT_ADDR_COMPARE, 8'h80, 8'hFF, "compare buffer");
    pin_both("phase pwm output", 600);
    wr(`ETT_ADDR_CONTROL, ctl(ETT_CS_DIV1, ETT_MODE_FAST_PWM, 2'b10));
    pin_both("fast pwm output", 600);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(i), 8'h00, 8'hFF, "reset again");
    check("pin after reset", 8'h00, {7'h00, cmp_pin});
    repeat (3) @(posedge clk);
    finish_test;
  end
endmodule
